// ===== verilog/cpsf_pkg.sv
// Constants, encodings and register map of the core state and flag block
// Overview of operation
// - 8-bit accumulator holds operands and receives ALU results.
// - 16-bit index pair built from upper and lower byte, also storage.
// - Reset loads the stack pointer with 0x00FF.
// - Stack low reset op sets low byte to 0xFF, keeps high byte.
// - Stack pointer decrements on each push, increments on each pull.
// - Program counter advances per fetch unless a load gives a target.
// - After reset the program counter loads from vector at 0xFFFE/0xFFFF.
// - Flag bits 6 and 5 always read as one and cannot change.
// - Overflow flag marks two's complement overflow, else cleared.
// - Half carry flag marks carry from bit 3 into bit 4 on adds.
// - Mask blocks maskable interrupts; set after stacking, before vector.
// - Interrupt entry never stacks the index upper byte.
// - Highest priority pending request is serviced first.
// - Return from interrupt restores stacked registers and the mask.
// - Mask is one after reset, cleared by clear mask, wait, stop or return op.
// - Negative flag follows bit 7 of the result.
// - Zero flag set when result equals 0x00.
// - Carry on add carry out, subtract borrow, shifts and bit tests.
// - Wait clears mask, gates clock; interrupt wake sets mask to one.
// - Stop clears mask, gates clock; resume after stabilisation delay.
// - Break loads software interrupt op, vector 0xFFFC or 0xFEFC.
// - Break starts after instruction end; return resumes once withdrawn.
package cpsf_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_IDX = 8'h04;
  localparam logic [7:0] OFS_SP = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_OPND = 8'h1C;
  localparam logic [7:0] OFS_TGT = 8'h20;
  localparam logic [7:0] OFS_IRQ = 8'h24;

  // Reset values and vectors
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] SP_LOW_RESET = 8'hFF;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_BREAK = 16'hFFFC;
  localparam logic [15:0] VEC_BREAK_MON = 16'hFEFC;
  localparam logic [7:0] SWI_OPCODE = 8'h83;

  // Flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam int FLG_ONE0 = 5;
  localparam int FLG_ONE1 = 6;
  localparam int FLG_V = 7;
  localparam logic [7:0] FLG_FIXED = 8'h60;

  // Status bit positions
  localparam int ST_WAIT = 0;
  localparam int ST_STOP = 1;
  localparam int ST_CLKEN = 2;
  localparam int ST_BREAK = 3;
  localparam int ST_INT = 4;

  // Oscillator stabilisation, in ref_clk cycles
  localparam int STAB_CYCLES = 4096;
  localparam int STAB_SHORT = 32;

  // Commands written to the command register
  typedef enum logic [4:0] {
    CMD_NOP = 5'h00, CMD_ADD = 5'h01, CMD_ADC = 5'h02, CMD_SUB = 5'h03,
    CMD_AND = 5'h04, CMD_ASL = 5'h05, CMD_ASR = 5'h06, CMD_ROL = 5'h07,
    CMD_PUSH_A = 5'h08, CMD_PULL_A = 5'h09, CMD_PUSH_IDXU = 5'h0A,
    CMD_PULL_IDXU = 5'h0B, CMD_RSP = 5'h0C, CMD_CLI = 5'h0D,
    CMD_SEI = 5'h0E, CMD_FETCH = 5'h0F, CMD_JUMP = 5'h10,
    CMD_RTI = 5'h11, CMD_WAIT = 5'h12, CMD_STOP = 5'h13,
    CMD_BITTEST = 5'h14, CMD_VECTOR = 5'h15, CMD_INSN_END = 5'h16
  } cpsf_cmd_e;

  // Gray coded power state
  typedef enum logic [1:0] {
    PS_RUN = 2'b00, PS_WAIT = 2'b01, PS_STOP = 2'b11, PS_WAKE = 2'b10
  } cpsf_pwr_e;

endpackage : cpsf_pkg

// ===== verilog/cpsf_alu.sv
// Eight bit ALU producing result and condition flags
`timescale 1ns/1ps
module cpsf_alu
  import cpsf_pkg::*;
(
  input wire logic [4:0] op,
  input wire logic [7:0] a,
  input wire logic [7:0] m,
  input wire logic c_in,
  output logic [7:0] res,
  output logic v,
  output logic h,
  output logic n,
  output logic z,
  output logic c,
  output logic flags_valid
);
  logic [8:0] sum;
  logic [4:0] low;

  always_comb begin
    sum = 9'h000;
    low = 5'h00;
    res = a;
    v = 1'b0;
    h = 1'b0;
    c = c_in;
    flags_valid = 1'b1;
    case (op)
      CMD_ADD, CMD_ADC: begin
        sum = {1'b0, a} + {1'b0, m} + {8'h00, (op == CMD_ADC) & c_in};
        low = {1'b0, a[3:0]} + {1'b0, m[3:0]}
            + {4'h0, (op == CMD_ADC) & c_in};
        res = sum[7:0];
        h = low[4];
        c = sum[8];
        v = (a[7] == m[7]) && (res[7] != a[7]);
      end
      CMD_SUB: begin
        sum = {1'b0, a} - {1'b0, m};
        res = sum[7:0];
        c = sum[8];
        v = (a[7] != m[7]) && (res[7] != a[7]);
      end
      CMD_AND: res = a & m;
      CMD_ASL: begin
        res = {a[6:0], 1'b0};
        c = a[7];
        v = a[7] ^ a[6];
      end
      CMD_ASR: begin
        res = {a[7], a[7:1]};
        c = a[0];
        v = a[7] ^ a[0];
      end
      CMD_ROL: begin
        res = {a[6:0], c_in};
        c = a[7];
        v = a[7] ^ a[6];
      end
      default: flags_valid = 1'b0;
    endcase
    n = res[7];
    z = (res == 8'h00);
  end
endmodule : cpsf_alu

// ===== verilog/cpsf_core_state.sv
// Core programmer state: registers, flags, stack, power and break entry
`timescale 1ns/1ps
module cpsf_core_state
  import cpsf_pkg::*;
#(
  parameter int STAB_LONG = STAB_CYCLES,
  parameter int NUM_IRQ = 4
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic break_req,
  input wire logic monitor_mode,
  input wire logic short_stop_rec,
  output logic core_clk_en,
  output logic [7:0] insn_reg
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] acc_q;
  logic [15:0] idx_q;
  logic [15:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0] flg_q;
  logic [7:0] opnd_q;
  logic [15:0] tgt_q;
  logic [NUM_IRQ-1:0] irq_en_q;
  logic [7:0] stk_mem_q [0:15];
  logic [15:0] rti_pc_q;
  logic [7:0] rti_flg_q;
  logic [7:0] rti_acc_q;
  logic [7:0] rti_x_q;
  logic in_break_q;
  logic in_int_q;
  logic reset_vec_q;
  cpsf_pwr_e pwr_q;
  cpsf_pwr_e pwr_d;
  logic [12:0] stab_cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes in its first access cycle
  logic wr_en;
  logic rd_en;
  cpsf_cmd_e cmd;
  logic cmd_go;
  logic [7:0] alu_res;
  logic alu_v;
  logic alu_h;
  logic alu_n;
  logic alu_z;
  logic alu_c;
  logic alu_ok;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pslverr = psel & penable & ~(hit(paddr, OFS_ACC)
    | hit(paddr, OFS_IDX) | hit(paddr, OFS_SP) | hit(paddr, OFS_PC)
    | hit(paddr, OFS_FLAGS) | hit(paddr, OFS_CMD) | hit(paddr, OFS_STAT)
    | hit(paddr, OFS_OPND) | hit(paddr, OFS_TGT) | hit(paddr, OFS_IRQ));
  assign cmd = cpsf_cmd_e'(pwdata[4:0]);
  // Commands are ignored while the core clock is gated
  assign cmd_go = wr_en & hit(paddr, OFS_CMD) & (pwr_q == PS_RUN);

  cpsf_alu u_alu (
    .op(pwdata[4:0]),
    .a(acc_q),
    .m(opnd_q),
    .c_in(flg_q[FLG_C]),
    .res(alu_res),
    .v(alu_v),
    .h(alu_h),
    .n(alu_n),
    .z(alu_z),
    .c(alu_c),
    .flags_valid(alu_ok)
  );

  // Highest priority is the lowest index of an enabled pending request
  logic irq_any;
  logic [NUM_IRQ-1:0] irq_pend;
  logic [7:0] irq_sel;
  assign irq_pend = irq_req & irq_en_q;
  assign irq_any = |irq_pend;
  always_comb begin
    irq_sel = 8'h00;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_pend[i]) begin
        irq_sel = 8'(i);
      end
    end
  end

  // Interrupt entry is taken at instruction end or in wait, with the mask clear
  logic take_int;
  logic take_brk;
  assign take_brk = cmd_go && (cmd == CMD_INSN_END) && break_req
    && !in_break_q;
  assign take_int = ((cmd_go && (cmd == CMD_INSN_END))
    || (pwr_q == PS_WAIT)) && irq_any && !flg_q[FLG_I]
    && !take_brk;

  ////////////////////////////////////////////////////////////////////////
  // Accumulator and index pair
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= 8'h00;
    end else if (cmd_go && (cmd == CMD_RTI)) begin
      acc_q <= rti_acc_q;
    end else if (cmd_go && (cmd == CMD_PULL_A)) begin
      acc_q <= stk_mem_q[sp_q[3:0] + 4'h1];
    end else if (cmd_go && alu_ok && cmd != CMD_NOP) begin
      acc_q <= alu_res;
    end else if (wr_en && hit(paddr, OFS_ACC)) begin
      acc_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      idx_q <= 16'h0000;
    end else if (cmd_go && (cmd == CMD_RTI)) begin
      idx_q[7:0] <= rti_x_q;
    end else if (cmd_go && (cmd == CMD_PULL_IDXU)) begin
      idx_q[15:8] <= stk_mem_q[sp_q[3:0] + 4'h1];
    end else if (wr_en && hit(paddr, OFS_IDX)) begin
      idx_q <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack pointer and stack storage (low 16 bytes mirrored)
  logic push_a;
  logic push_h;
  logic pull_one;
  assign push_a = cmd_go && (cmd == CMD_PUSH_A);
  assign push_h = cmd_go && (cmd == CMD_PUSH_IDXU);
  assign pull_one = cmd_go && ((cmd == CMD_PULL_A)
    || (cmd == CMD_PULL_IDXU));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sp_q <= SP_RESET;
    end else if (cmd_go && (cmd == CMD_RSP)) begin
      sp_q[7:0] <= SP_LOW_RESET;
    end else if (push_a || push_h) begin
      sp_q <= sp_q - 16'h0001;
    end else if (pull_one) begin
      sp_q <= sp_q + 16'h0001;
    end else if (wr_en && hit(paddr, OFS_SP)) begin
      sp_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push_a) begin
      stk_mem_q[sp_q[3:0]] <= acc_q;
    end else if (push_h) begin
      stk_mem_q[sp_q[3:0]] <= idx_q[15:8];
    end
  end

  // Interrupt frame: index upper byte is deliberately not saved
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rti_pc_q <= 16'h0000;
      rti_flg_q <= FLG_FIXED;
      rti_acc_q <= 8'h00;
      rti_x_q <= 8'h00;
    end else if (take_int || take_brk) begin
      rti_pc_q <= pc_q;
      rti_flg_q <= flg_q;
      rti_acc_q <= acc_q;
      rti_x_q <= idx_q[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= VEC_RESET;
    end else if (reset_vec_q && wr_en && hit(paddr, OFS_TGT)) begin
      pc_q <= pwdata[15:0];
    end else if (take_brk) begin
      pc_q <= monitor_mode ? VEC_BREAK_MON : VEC_BREAK;
    end else if (take_int) begin
      pc_q <= VEC_RESET - {7'h00, irq_sel, 1'b0} - 16'h0002;
    end else if (cmd_go && (cmd == CMD_RTI) && !(in_break_q
        && break_req)) begin
      pc_q <= rti_pc_q;
    end else if (cmd_go && (cmd == CMD_JUMP || cmd == CMD_VECTOR)) begin
      pc_q <= tgt_q;
    end else if (cmd_go && (cmd == CMD_FETCH)) begin
      pc_q <= pc_q + 16'h0001;
    end else if (wr_en && hit(paddr, OFS_PC)) begin
      pc_q <= pwdata[15:0];
    end
  end

  // The reset vector contents arrive through the target register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reset_vec_q <= 1'b1;
    end else if (reset_vec_q && wr_en && hit(paddr, OFS_TGT)) begin
      reset_vec_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tgt_q <= 16'h0000;
      opnd_q <= 8'h00;
      irq_en_q <= '1;
    end else begin
      if (wr_en && hit(paddr, OFS_TGT)) begin
        tgt_q <= pwdata[15:0];
      end
      if (wr_en && hit(paddr, OFS_OPND)) begin
        opnd_q <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, OFS_IRQ)) begin
        irq_en_q <= pwdata[NUM_IRQ-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Condition flags
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flg_q <= FLG_FIXED | (8'h01 << FLG_I);
    end else begin
      if (take_int || take_brk) begin
        flg_q[FLG_I] <= 1'b1;
      end else if (cmd_go && (cmd == CMD_RTI) && !(in_break_q
          && break_req)) begin
        flg_q <= rti_flg_q | FLG_FIXED;
      end else if (cmd_go && (cmd == CMD_CLI || cmd == CMD_WAIT
          || cmd == CMD_STOP)) begin
        flg_q[FLG_I] <= 1'b0;
      end else if (cmd_go && (cmd == CMD_SEI)) begin
        flg_q[FLG_I] <= 1'b1;
      end else if (cmd_go && (cmd == CMD_BITTEST)) begin
        flg_q[FLG_C] <= opnd_q[acc_q[2:0]];
      end else if (cmd_go && alu_ok && cmd != CMD_NOP) begin
        flg_q[FLG_V] <= alu_v;
        flg_q[FLG_N] <= alu_n;
        flg_q[FLG_Z] <= alu_z;
        flg_q[FLG_C] <= alu_c;
        if (cmd == CMD_ADD || cmd == CMD_ADC) begin
          flg_q[FLG_H] <= alu_h;
        end
      end else if (wr_en && hit(paddr, OFS_FLAGS)) begin
        // Software may not clear the mask this way
        flg_q[FLG_V] <= pwdata[FLG_V];
        flg_q[FLG_H] <= pwdata[FLG_H];
        flg_q[FLG_I] <= flg_q[FLG_I] | pwdata[FLG_I];
        flg_q[FLG_N] <= pwdata[FLG_N];
        flg_q[FLG_Z] <= pwdata[FLG_Z];
        flg_q[FLG_C] <= pwdata[FLG_C];
      end
      flg_q[FLG_ONE1] <= 1'b1;
      flg_q[FLG_ONE0] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Break and interrupt state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in_break_q <= 1'b0;
      in_int_q <= 1'b0;
      insn_reg <= 8'h00;
    end else if (take_brk) begin
      in_break_q <= 1'b1;
      insn_reg <= SWI_OPCODE;
    end else if (take_int) begin
      in_int_q <= 1'b1;
    end else if (cmd_go && (cmd == CMD_RTI)) begin
      if (!(in_break_q && break_req)) begin
        in_break_q <= 1'b0;
        in_int_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low power modes
  logic stab_done;
  assign stab_done = short_stop_rec
    ? (stab_cnt_q >= 13'(STAB_SHORT - 1))
    : (stab_cnt_q >= 13'(STAB_LONG - 1));

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PS_RUN: begin
        if (cmd_go && cmd == CMD_WAIT) pwr_d = PS_WAIT;
        else if (cmd_go && cmd == CMD_STOP) pwr_d = PS_STOP;
      end
      PS_WAIT: if (take_int) pwr_d = PS_RUN;
      PS_STOP: if (irq_any) pwr_d = PS_WAKE;
      PS_WAKE: if (stab_done) pwr_d = PS_RUN;
      default: pwr_d = PS_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pwr_q <= PS_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stab_cnt_q <= 13'h0000;
    end else if (pwr_q == PS_WAKE) begin
      stab_cnt_q <= stab_cnt_q + 13'h0001;
    end else begin
      stab_cnt_q <= 13'h0000;
    end
  end

  assign core_clk_en = (pwr_q == PS_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_ACC: prdata <= {24'h00_0000, acc_q};
        OFS_IDX: prdata <= {16'h0000, idx_q};
        OFS_SP: prdata <= {16'h0000, sp_q};
        OFS_PC: prdata <= {16'h0000, pc_q};
        OFS_FLAGS: prdata <= {24'h00_0000, flg_q | FLG_FIXED};
        OFS_STAT: prdata <= {27'h000_0000, in_int_q, in_break_q,
          core_clk_en, pwr_q == PS_STOP || pwr_q == PS_WAKE,
          pwr_q == PS_WAIT};
        OFS_OPND: prdata <= {24'h00_0000, opnd_q};
        OFS_TGT: prdata <= {16'h0000, tgt_q};
        OFS_IRQ: prdata <= {{(32 - NUM_IRQ){1'b0}}, irq_en_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : cpsf_core_state

// ===== verif/cpsf_core_state_chk.sv
// Port-level checker for the core state and flag block
`timescale 1ns/1ps
module cpsf_core_state_chk
  import cpsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic core_clk_en,
  input wire logic [7:0] insn_reg
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  logic acc_ph;
  logic cmd_wr;
  assign acc_ph = psel && penable;
  // Commands only count while the core clock runs
  assign cmd_wr = acc_ph && pwrite && paddr == OFS_CMD && core_clk_en;
  ////////////////////////////////////////////////////////////////////////////
  a_ready_high: assert property (psel |-> pready)
    else $error("ready low in a transfer");
  a_err_window: assert property (!acc_ph |-> !pslverr)
    else $error("error outside access");
  a_err_unmap: assert property (acc_ph && paddr > OFS_IRQ |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property
    (acc_ph && paddr <= OFS_IRQ && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_fixed_ones: assert property (
    acc_ph && !pwrite && paddr == OFS_FLAGS |-> prdata[6:5] == 2'b11)
    else $error("fixed flag bits not one");
  a_rdata_hold: assert property
    (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  a_wait_gate: assert property (
    cmd_wr && pwdata[4:0] == CMD_WAIT |=> !core_clk_en)
    else $error("wait left the clock on");
  a_stop_gate: assert property (
    cmd_wr && pwdata[4:0] == CMD_STOP |=> !core_clk_en [*8])
    else $error("stop resumed too soon");
  a_break_op: assert property (
    $changed(insn_reg) |-> insn_reg == SWI_OPCODE)
    else $error("instruction register wrong on break");
endmodule : cpsf_core_state_chk

// ===== verif/test_cpu_state_and_flags.sv
// Self-checking bench for the core state and flag block
`timescale 1ns/1ps
module test_cpu_state_and_flags import cpsf_pkg::*;;
  // Shortened long stop recovery so both delays fit in a quick run
  localparam int STAB = 60;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, insn_reg, m_acc, m_flg;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] irq_req;
  logic break_req, monitor_mode, short_stop_rec, core_clk_en, rerr;
  int n_mismatch, n_checks;
  cpsf_cmd_e ops [8] = '{CMD_ADD, CMD_ADC, CMD_SUB, CMD_AND,
                         CMD_ASL, CMD_ASR, CMD_ROL, CMD_BITTEST};
  cpsf_core_state #(.STAB_LONG(STAB), .NUM_IRQ(4)) cpsf_core_state_i (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
    .break_req(break_req), .monitor_mode(monitor_mode),
    .short_stop_rec(short_stop_rec), .core_clk_en(core_clk_en),
    .insn_reg(insn_reg));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo(input int k);
    if (k >= 1000) begin
      n_mismatch++;
      summarize();
    end
  endtask : tmo
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 1000);
    tmo(k);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask : rc
  task automatic cmd(input cpsf_cmd_e c);
    apb(1'b1, OFS_CMD, {27'h0, c});
  endtask : cmd
  task automatic wclk(output int k);
    k = 0;
    while (core_clk_en !== 1'b1 && k < 1000) begin
      @(posedge ref_clk);
      k++;
    end
    tmo(k);
  endtask : wclk
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    m_flg = 8'h68;
  endtask : do_reset
  // Reference flag model; untouched flags keep their old value
  task automatic alu(input cpsf_cmd_e op, input logic [7:0] a, m);
    logic [8:0] s;
    logic [4:0] hs;
    logic ci;
    ci = m_flg[FLG_C];
    case (op)
      CMD_ADD, CMD_ADC: begin
        ci = ci & (op == CMD_ADC);
        s = a + m + ci;
        hs = a[3:0] + m[3:0] + ci;
        m_flg[FLG_H] = hs[4];
        m_flg[FLG_V] = (a[7] == m[7]) && (s[7] != a[7]);
      end
      CMD_SUB: begin
        s = {1'b0, a} - {1'b0, m};
        m_flg[FLG_V] = (a[7] != m[7]) && (s[7] != a[7]);
      end
      CMD_AND: begin
        s = {ci, a & m};
        m_flg[FLG_V] = 1'b0;
      end
      CMD_ASL: s = {a, 1'b0};
      CMD_ASR: s = {a[0], a[7], a[7:1]};
      CMD_BITTEST: s = {m[a[2:0]], a};
      default: s = {a, ci};
    endcase
    if (op >= CMD_ASL && op <= CMD_ROL) m_flg[FLG_V] = s[8] ^ s[7];
    m_flg[FLG_C] = s[8];
    // Bit test leaves the accumulator as written, so s[7:0] is a
    m_acc = s[7:0];
    if (op != CMD_BITTEST) begin
      m_flg[FLG_N] = s[7];
      m_flg[FLG_Z] = (s[7:0] == 8'h00);
    end
  endtask : alu
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] w;
    logic [7:0] a, m;
    int k;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    irq_req = 4'h0;
    break_req = 1'b0;
    monitor_mode = 1'b0;
    short_stop_rec = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    k = $urandom(32'h572a_5329);
    do_reset();
    rc(OFS_ACC, 32'h0000_0000);
    rc(OFS_IDX, 32'h0000_0000);
    rc(OFS_SP, {16'h0, SP_RESET});
    rc(OFS_PC, {16'h0, VEC_RESET});
    rc(OFS_FLAGS, 32'h0000_0068);
    rd(8'h40);
    chk(rerr, 1);
    w = $urandom;
    wr(OFS_IDX, w);
    rc(OFS_IDX, w & 32'h0000_ffff);
    wr(OFS_FLAGS, w);
    m_flg = w[7:0] | 8'h68;
    rc(OFS_FLAGS, {24'h0, m_flg});
    for (int i = 0; i < 32; i++) begin
      a = (i < 8) ? 8'h80 : 8'($urandom);
      m = (i < 8) ? 8'h80 : 8'($urandom);
      wr(OFS_ACC, {24'h0, a});
      wr(OFS_OPND, {24'h0, m});
      cmd(ops[i % 8]);
      alu(ops[i % 8], a, m);
      rc(OFS_ACC, {24'h0, m_acc});
      rc(OFS_FLAGS, {24'h0, m_flg});
    end
    wr(OFS_SP, 32'h0000_0120);
    wr(OFS_ACC, 32'h0000_005a);
    cmd(CMD_PUSH_A);
    rc(OFS_SP, 32'h0000_011f);
    wr(OFS_ACC, 32'h0000_0000);
    cmd(CMD_PULL_A);
    rc(OFS_ACC, 32'h0000_005a);
    rc(OFS_SP, 32'h0000_0120);
    wr(OFS_IDX, 32'h0000_a5c3);
    cmd(CMD_PUSH_IDXU);
    wr(OFS_IDX, 32'h0000_0000);
    cmd(CMD_PULL_IDXU);
    rc(OFS_IDX, 32'h0000_a500);
    wr(OFS_SP, 32'h0000_1234);
    cmd(CMD_RSP);
    rc(OFS_SP, 32'h0000_12ff);
    w = $urandom & 32'h0000_fff0;
    wr(OFS_TGT, w);
    rc(OFS_PC, w);
    repeat (3) cmd(CMD_FETCH);
    rc(OFS_PC, w + 3);
    wr(OFS_TGT, 32'h0000_4321);
    cmd(CMD_JUMP);
    rc(OFS_PC, 32'h0000_4321);
    wr(OFS_IRQ, 32'h0000_000f);
    irq_req <= 4'b0110;
    cmd(CMD_INSN_END);
    rc(OFS_PC, 32'h0000_4321);
    cmd(CMD_CLI);
    rd(OFS_FLAGS);
    chk(rdat[FLG_I], 0);
    cmd(CMD_INSN_END);
    rc(OFS_PC, 32'h0000_fffa);
    rd(OFS_FLAGS);
    chk(rdat[FLG_I], 1);
    irq_req <= 4'b0000;
    cmd(CMD_RTI);
    rc(OFS_PC, 32'h0000_4321);
    rd(OFS_FLAGS);
    chk(rdat[FLG_I], 0);
    rc(OFS_IDX, 32'h0000_a500);
    for (int j = 0; j < 2; j++) begin
      monitor_mode <= (j == 1);
      break_req <= 1'b1;
      cmd(CMD_INSN_END);
      chk(insn_reg, {24'h0, SWI_OPCODE});
      w = {16'h0, (j == 1) ? VEC_BREAK_MON : VEC_BREAK};
      rc(OFS_PC, w);
      cmd(CMD_RTI);
      rc(OFS_PC, w);
      break_req <= 1'b0;
      cmd(CMD_RTI);
      rc(OFS_PC, 32'h0000_4321);
    end
    cmd(CMD_SEI);
    cmd(CMD_WAIT);
    chk(core_clk_en, 0);
    rd(OFS_FLAGS);
    chk(rdat[FLG_I], 0);
    rd(OFS_STAT);
    chk(rdat[ST_WAIT], 1);
    irq_req <= 4'b0001;
    wclk(k);
    rc(OFS_PC, 32'h0000_fffc);
    irq_req <= 4'b0000;
    cmd(CMD_RTI);
    rd(OFS_FLAGS);
    chk(rdat[FLG_I], 0);
    for (int j = 0; j < 2; j++) begin
      short_stop_rec <= (j == 1);
      cmd(CMD_STOP);
      chk(core_clk_en, 0);
      irq_req <= 4'b0010;
      wclk(k);
      w = (j == 1) ? STAB_SHORT : STAB;
      chk(k >= w && k <= w + 8, 1);
      irq_req <= 4'b0000;
      rd(OFS_FLAGS);
      chk(rdat[FLG_I], 0);
    end
    cmd(CMD_STOP);
    do_reset();
    chk(core_clk_en, 1);
    rc(OFS_FLAGS, 32'h0000_0068);
    summarize();
  end
endmodule : test_cpu_state_and_flags

bind cpsf_core_state cpsf_core_state_chk cpsf_core_state_chk_i (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_clk_en(core_clk_en),
  .insn_reg(insn_reg));
